// *** rtl/fifo_irq_pkg.sv ***
package fifo_irq_pkg;

  // ********
  // Register map
  // ********
  localparam int          ADDR_W     = 12;
  localparam logic [11:0] OFS_STATUS = 12'hE04;
  localparam logic [11:0] OFS_TRIG   = 12'hE08;
  localparam logic [11:0] OFS_ENSET  = 12'hE10;
  localparam logic [11:0] OFS_ENCLR  = 12'hE14;
  localparam logic [11:0] OFS_VIEW   = 12'hE18;

  // ********
  // Field positions
  // ********
  localparam int RX_POINT_LSB = 16;
  localparam int TX_POINT_LSB = 8;
  localparam int RX_ON_BIT    = 1;
  localparam int TX_ON_BIT    = 0;
  localparam int SRC_RX_LVL   = 3;
  localparam int SRC_TX_LVL   = 2;
  localparam int SRC_RX_ERR   = 1;
  localparam int SRC_TX_ERR   = 0;
  localparam int SRC_N        = 4;

  // ********
  // Codes and reset values
  // ********
  localparam logic [3:0]  POINT_MAX  = 4'h3;
  localparam logic [3:0]  POINT_RST  = 4'h0;
  localparam logic [3:0]  SRC_RST    = 4'h0;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLV   = 2'h2;
  localparam logic [31:0] DATA_ZERO  = 32'h0000_0000;

endpackage

// *** rtl/level_trig_if.sv ***
`timescale 1ns/1ps
interface level_trig_if #(
  parameter int LEVEL_W = 3
);
  logic               rx_push;
  logic [LEVEL_W-1:0] rx_level;
  logic               tx_pop;
  logic [LEVEL_W-1:0] tx_level;
  logic [3:0]         rx_point;
  logic [3:0]         tx_point;
  logic               rx_on;
  logic               tx_on;
  logic               rx_hit;
  logic               tx_hit;

  modport ctrl (output rx_push, rx_level, tx_pop, tx_level, rx_point, tx_point,
                output rx_on, tx_on, input rx_hit, tx_hit);
  modport eval (input rx_push, rx_level, tx_pop, tx_level, rx_point, tx_point,
                input rx_on, tx_on, output rx_hit, tx_hit);
endinterface

// *** rtl/level_trigger_eval.sv ***
`timescale 1ns/1ps
module level_trigger_eval #(
  parameter int LEVEL_W = 3
) (
  level_trig_if.eval trig
);

  // ********
  // Level compare
  // ********
  wire                rx_code_ok;
  wire                tx_code_ok;
  wire [LEVEL_W-1:0]  rx_goal;
  wire [LEVEL_W-1:0]  tx_goal;

  // Reserved codes never fire
  assign rx_code_ok = trig.rx_point <= fifo_irq_pkg::POINT_MAX;
  assign tx_code_ok = trig.tx_point <= fifo_irq_pkg::POINT_MAX;
  // Code n means n+1 stored entries on the receive side
  assign rx_goal    = LEVEL_W'(trig.rx_point) + LEVEL_W'(1);
  assign tx_goal    = LEVEL_W'(trig.tx_point);

  // Checked only as an entry is pushed on the receive side or popped on the transmit side
  assign trig.rx_hit = trig.rx_on & trig.rx_push & rx_code_ok
                     & (trig.rx_level == rx_goal);
  assign trig.tx_hit = trig.tx_on & trig.tx_pop & tx_code_ok
                     & (trig.tx_level == tx_goal);

endmodule // level_trigger_eval

// *** rtl/serial_fifo_level_trigger_irq.sv ***
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
module serial_fifo_level_trigger_irq #(
  parameter int LEVEL_W = 3
) (
  input  wire logic                              CORE_CLK,
  input  wire logic                              RST_B,
  input  wire logic                              CE,
  input  wire logic [fifo_irq_pkg::ADDR_W-1:0]   AWADDR,
  input  wire logic                              AWVALID,
  output logic                                   AWREADY,
  input  wire logic [31:0]                       WDATA,
  input  wire logic [3:0]                        WSTRB,
  input  wire logic                              WVALID,
  output logic                                   WREADY,
  output logic [1:0]                             BRESP,
  output logic                                   BVALID,
  input  wire logic                              BREADY,
  input  wire logic [fifo_irq_pkg::ADDR_W-1:0]   ARADDR,
  input  wire logic                              ARVALID,
  output logic                                   ARREADY,
  output logic [31:0]                            RDATA,
  output logic [1:0]                             RRESP,
  output logic                                   RVALID,
  input  wire logic                              RREADY,
  input  wire logic                              RX_PUSH,
  input  wire logic [LEVEL_W-1:0]                RX_LEVEL,
  input  wire logic                              TX_POP,
  input  wire logic [LEVEL_W-1:0]                TX_LEVEL,
  input  wire logic                              RX_OVERFLOW,
  input  wire logic                              TX_OVERFLOW,
  input  wire logic                              TX_UNDERFLOW,
  input  wire logic                              RX_DMA_SELECT,
  input  wire logic                              TX_DMA_SELECT,
  output logic                                   RX_DMA_REQ,
  output logic                                   TX_DMA_REQ,
  output logic                                   IRQ
);

  // ********
  // Declarations
  // ********
  localparam int AW = fifo_irq_pkg::ADDR_W;
  localparam int SN = fifo_irq_pkg::SRC_N;

  logic [AW-1:0]  wr_addr;
  logic [31:0]    wr_data;
  logic [3:0]     wr_strb;
  logic           aw_full;
  logic           w_full;
  logic [3:0]     rx_point;
  logic [3:0]     tx_point;
  logic           rx_on;
  logic           tx_on;
  logic [SN-1:0]  enable;
  logic [SN-1:0]  status;

  wire            aw_take;
  wire            w_take;
  wire            ar_take;
  wire            do_write;
  wire            next_aw_full;
  wire            next_w_full;
  wire            next_rvalid;
  wire            w_trig;
  wire            w_status;
  wire            w_enset;
  wire            w_enclr;
  wire            w_view;
  wire            w_hit;
  wire            r_trig;
  wire            r_status;
  wire            r_en;
  wire            r_view;
  wire            r_hit;
  wire [31:0]     rd_mux;
  wire [SN-1:0]   set_mask;
  wire [SN-1:0]   clr_mask;
  wire [SN-1:0]   stat_clr;
  wire [SN-1:0]   events;
  wire [SN-1:0]   next_enable;
  wire [SN-1:0]   next_status;
  wire [SN-1:0]   view;
  wire            rx_hit;
  wire            tx_hit;

  // ********
  // Level trigger evaluation
  // ********
  level_trig_if #(.LEVEL_W(LEVEL_W)) trig ();

  assign trig.rx_push  = RX_PUSH;
  assign trig.rx_level = RX_LEVEL;
  assign trig.tx_pop   = TX_POP;
  assign trig.tx_level = TX_LEVEL;
  assign trig.rx_point = rx_point;
  assign trig.tx_point = tx_point;
  assign trig.rx_on    = rx_on;
  assign trig.tx_on    = tx_on;
  assign rx_hit        = trig.rx_hit;
  assign tx_hit        = trig.tx_hit;

  level_trigger_eval #(
    .LEVEL_W (LEVEL_W)
  ) u_eval (
    .trig (trig.eval)
  );

  // ********
  // Bus handshakes
  // ********
  assign aw_take      = AWVALID & AWREADY;
  assign w_take       = WVALID & WREADY;
  assign ar_take      = ARVALID & ARREADY;
  assign do_write     = aw_full & w_full & ~BVALID;
  assign next_aw_full = (aw_full & ~do_write) | aw_take;
  assign next_w_full  = (w_full & ~do_write) | w_take;
  assign next_rvalid  = ar_take | (RVALID & ~RREADY);

  // ********
  // Address decode
  // ********
  assign w_trig   = wr_addr[AW-1:2] == fifo_irq_pkg::OFS_TRIG[AW-1:2];
  assign w_status = wr_addr[AW-1:2] == fifo_irq_pkg::OFS_STATUS[AW-1:2];
  assign w_enset  = wr_addr[AW-1:2] == fifo_irq_pkg::OFS_ENSET[AW-1:2];
  assign w_enclr  = wr_addr[AW-1:2] == fifo_irq_pkg::OFS_ENCLR[AW-1:2];
  assign w_view   = wr_addr[AW-1:2] == fifo_irq_pkg::OFS_VIEW[AW-1:2];
  assign w_hit    = w_trig | w_status | w_enset | w_enclr | w_view;

  assign r_trig   = ARADDR[AW-1:2] == fifo_irq_pkg::OFS_TRIG[AW-1:2];
  assign r_status = ARADDR[AW-1:2] == fifo_irq_pkg::OFS_STATUS[AW-1:2];
  assign r_en     = (ARADDR[AW-1:2] == fifo_irq_pkg::OFS_ENSET[AW-1:2])
                  | (ARADDR[AW-1:2] == fifo_irq_pkg::OFS_ENCLR[AW-1:2]);
  assign r_view   = ARADDR[AW-1:2] == fifo_irq_pkg::OFS_VIEW[AW-1:2];
  assign r_hit    = r_trig | r_status | r_en | r_view;

  // Reserved bits read as zero
  assign rd_mux = r_trig   ? {12'h000, rx_point, 4'h0, tx_point, 6'h00, rx_on, tx_on}
                : r_status ? {28'h0000000, status}
                : r_en     ? {28'h0000000, enable}
                : r_view   ? {28'h0000000, view}
                :            fifo_irq_pkg::DATA_ZERO;

  // ********
  // Enables, flags and view
  // ********
  assign set_mask = (do_write & w_enset & wr_strb[0]) ? wr_data[SN-1:0] : '0;
  assign clr_mask = (do_write & w_enclr & wr_strb[0]) ? wr_data[SN-1:0] : '0;
  assign stat_clr = (do_write & w_status & wr_strb[0]) ? wr_data[SN-1:0] : '0;
  assign next_enable = (enable | set_mask) & ~clr_mask;

  assign events[fifo_irq_pkg::SRC_RX_LVL] = rx_hit;
  assign events[fifo_irq_pkg::SRC_TX_LVL] = tx_hit;
  assign events[fifo_irq_pkg::SRC_RX_ERR] = RX_OVERFLOW;
  assign events[fifo_irq_pkg::SRC_TX_ERR] = TX_OVERFLOW | TX_UNDERFLOW;

  // A new event wins over a clear in the same cycle
  assign next_status = (status & ~stat_clr) | events;
  // Each enable bit gates its own source
  assign view = status & enable;

  // ********
  // Bus registers
  // ********
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      aw_full <= 1'b0;
      w_full  <= 1'b0;
      AWREADY <= 1'b0;
      WREADY  <= 1'b0;
      BVALID  <= 1'b0;
      BRESP   <= fifo_irq_pkg::RESP_OKAY;
    end else if (CE) begin
      aw_full <= next_aw_full;
      w_full  <= next_w_full;
      AWREADY <= ~next_aw_full;
      WREADY  <= ~next_w_full;
      if (do_write) begin
        BVALID <= 1'b1;
        BRESP  <= w_hit ? fifo_irq_pkg::RESP_OKAY : fifo_irq_pkg::RESP_SLV;
      end else if (BREADY) begin
        BVALID <= 1'b0;
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      wr_addr <= '0;
      wr_data <= fifo_irq_pkg::DATA_ZERO;
      wr_strb <= 4'h0;
    end else if (CE) begin
      if (aw_take) begin
        wr_addr <= AWADDR;
      end
      if (w_take) begin
        wr_data <= WDATA;
        wr_strb <= WSTRB;
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      ARREADY <= 1'b0;
      RVALID  <= 1'b0;
      RDATA   <= fifo_irq_pkg::DATA_ZERO;
      RRESP   <= fifo_irq_pkg::RESP_OKAY;
    end else if (CE) begin
      ARREADY <= ~next_rvalid;
      RVALID  <= next_rvalid;
      if (ar_take) begin
        RDATA <= rd_mux;
        RRESP <= r_hit ? fifo_irq_pkg::RESP_OKAY : fifo_irq_pkg::RESP_SLV;
      end
    end
  end

  // ********
  // Trigger configuration
  // ********
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      rx_point <= fifo_irq_pkg::POINT_RST;
      tx_point <= fifo_irq_pkg::POINT_RST;
      rx_on    <= 1'b0;
      tx_on    <= 1'b0;
    end else if (CE && do_write && w_trig) begin
      if (wr_strb[2]) begin
        rx_point <= wr_data[fifo_irq_pkg::RX_POINT_LSB +: 4];
      end
      if (wr_strb[1]) begin
        tx_point <= wr_data[fifo_irq_pkg::TX_POINT_LSB +: 4];
      end
      if (wr_strb[0]) begin
        rx_on <= wr_data[fifo_irq_pkg::RX_ON_BIT];
        tx_on <= wr_data[fifo_irq_pkg::TX_ON_BIT];
      end
    end
  end

  // ********
  // Interrupt and DMA outputs
  // ********
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      enable     <= fifo_irq_pkg::SRC_RST;
      status     <= fifo_irq_pkg::SRC_RST;
      IRQ        <= 1'b0;
      RX_DMA_REQ <= 1'b0;
      TX_DMA_REQ <= 1'b0;
    end else if (CE) begin
      enable     <= next_enable;
      status     <= next_status;
      IRQ        <= |(next_status & next_enable);
      RX_DMA_REQ <= rx_hit & RX_DMA_SELECT;
      TX_DMA_REQ <= tx_hit & TX_DMA_SELECT;
    end
  end

  // ********
  // Assertions
  // ********
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_B);

  rx_point_hit_a: assert property (
    CE && RX_PUSH && rx_on && rx_point == 4'h1 && RX_LEVEL == LEVEL_W'(2)
    |=> status[fifo_irq_pkg::SRC_RX_LVL])
    else $error("receive level trigger missed at two entries");

  rx_reserved_a: assert property (
    CE && rx_point > fifo_irq_pkg::POINT_MAX |-> !rx_hit)
    else $error("reserved receive code produced a trigger");

  tx_point_hit_a: assert property (
    CE && TX_POP && tx_on && tx_point == 4'h0 && TX_LEVEL == LEVEL_W'(0)
    |=> status[fifo_irq_pkg::SRC_TX_LVL])
    else $error("transmit empty trigger missed");

  rx_off_quiet_a: assert property (
    CE && !rx_on |-> !rx_hit ##1 !RX_DMA_REQ)
    else $error("receive trigger while disabled");

  tx_off_quiet_a: assert property (
    CE && !tx_on |-> !tx_hit ##1 !TX_DMA_REQ)
    else $error("transmit trigger while disabled");

  rx_dma_req_a: assert property (
    CE && rx_hit && RX_DMA_SELECT |=> RX_DMA_REQ ##1 (!RX_DMA_REQ || $past(rx_hit) || !$past(CE)))
    else $error("receive DMA request wrong");

  tx_dma_req_a: assert property (
    CE |=> TX_DMA_REQ == ($past(tx_hit) && $past(TX_DMA_SELECT)))
    else $error("transmit DMA request wrong");

  enable_set_a: assert property (
    CE && do_write && w_enset && wr_strb[0] && wr_data[3]
    |=> enable[3] && ($past(enable) & ~enable) == 4'h0)
    else $error("enable set write failed or cleared a bit");

  enable_hold_a: assert property (
    CE && !(do_write && w_enclr) |=> (($past(enable) & ~enable) == 4'h0))
    else $error("enable cleared outside the clear register");

  rx_err_set_a: assert property (
    CE && RX_OVERFLOW |=> status[fifo_irq_pkg::SRC_RX_ERR])
    else $error("receive overflow not flagged");

  tx_err_set_a: assert property (
    CE && (TX_OVERFLOW || TX_UNDERFLOW) |=> status[fifo_irq_pkg::SRC_TX_ERR])
    else $error("transmit error not flagged");

  view_read_a: assert property (
    CE && ar_take && r_view |=> RVALID && RDATA == {28'h0000000, $past(view)})
    else $error("pending view read wrong");

  irq_level_a: assert property (
    IRQ == |view)
    else $error("interrupt output does not match pending view");

  irq_rise_c: cover property (CE && !IRQ ##1 IRQ);
  rx_dma_c:   cover property (RX_DMA_REQ);
  en_clear_c: cover property (CE && do_write && w_enclr ##1 !IRQ);
  set_clr_c:  cover property (CE && |(stat_clr & events));

endmodule // serial_fifo_level_trigger_irq

// *** sim/dma_req_model.sv ***
`timescale 1ns/1ps
// ********
// DMA request controller that counts request pulses
// ********
module dma_req_model (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       rx_req,
  input  wire logic       tx_req,
  output logic      [7:0] rx_count,
  output logic      [7:0] tx_count
);
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rx_count <= 8'h00;
      tx_count <= 8'h00;
    end else begin
      rx_count <= rx_count + {7'h00, rx_req};
      tx_count <= tx_count + {7'h00, tx_req};
    end
  end
endmodule // dma_req_model

// *** sim/test_serial_fifo_level_trigger_irq.sv ***
`timescale 1ns/1ps
module test_serial_fifo_level_trigger_irq;
  typedef struct packed {
    logic [31:0] cfg;
    logic        is_tx;
    logic [2:0]  lvl;
    logic [3:0]  st;
  } row_t;
  logic        CORE_CLK = 1'b0;
  logic        rst_b    = 1'b0;
  logic [11:0] aw_addr  = 12'h000;
  logic [11:0] ar_addr  = 12'h000;
  logic [31:0] w_data   = 32'h0000_0000;
  logic        aw_valid = 1'b0;
  logic        w_valid  = 1'b0;
  logic        b_ready  = 1'b0;
  logic        ar_valid = 1'b0;
  logic        r_ready  = 1'b0;
  logic [4:0]  evt      = 5'h00;
  logic [2:0]  lvl      = 3'h0;
  logic        rx_sel   = 1'b1;
  logic        tx_sel   = 1'b1;
  logic        ce       = 1'b1;
  logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, RX_DMA_REQ, TX_DMA_REQ, IRQ;
  logic [1:0]  BRESP, RRESP, r;
  logic [31:0] RDATA, d;
  logic [7:0]  rx_cnt, tx_cnt;
  int          n_fail     = 0;
  int          num_checks = 0;
  // Each row: config, direction, level after the transfer, expected status
  row_t rows [12] = '{
    '{32'h0000_0002, 1'b0, 3'h1, 4'h8}, '{32'h0001_0002, 1'b0, 3'h2, 4'h8},
    '{32'h0002_0002, 1'b0, 3'h3, 4'h8}, '{32'h0003_0002, 1'b0, 3'h4, 4'h8},
    '{32'h0003_0002, 1'b0, 3'h3, 4'h0}, '{32'h0000_0000, 1'b0, 3'h1, 4'h0},
    '{32'h0004_0002, 1'b0, 3'h5, 4'h0}, '{32'h0000_0001, 1'b1, 3'h0, 4'h4},
    '{32'h0000_0101, 1'b1, 3'h1, 4'h4}, '{32'h0000_0201, 1'b1, 3'h2, 4'h4},
    '{32'h0000_0301, 1'b1, 3'h3, 4'h4}, '{32'h0000_0300, 1'b1, 3'h3, 4'h0}};

  always #12.5 CORE_CLK = ~CORE_CLK;

  serial_fifo_level_trigger_irq DUT (
    .CORE_CLK(CORE_CLK), .RST_B(rst_b), .CE(ce),
    .AWADDR(aw_addr), .AWVALID(aw_valid), .AWREADY(AWREADY),
    .WDATA(w_data), .WSTRB(4'hF), .WVALID(w_valid), .WREADY(WREADY),
    .BRESP(BRESP), .BVALID(BVALID), .BREADY(b_ready),
    .ARADDR(ar_addr), .ARVALID(ar_valid), .ARREADY(ARREADY),
    .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(r_ready),
    .RX_PUSH(evt[4]), .RX_LEVEL(lvl), .TX_POP(evt[3]), .TX_LEVEL(lvl),
    .RX_OVERFLOW(evt[2]), .TX_OVERFLOW(evt[1]), .TX_UNDERFLOW(evt[0]),
    .RX_DMA_SELECT(rx_sel), .TX_DMA_SELECT(tx_sel),
    .RX_DMA_REQ(RX_DMA_REQ), .TX_DMA_REQ(TX_DMA_REQ), .IRQ(IRQ));

  dma_req_model dma (
    .clk(CORE_CLK), .rst_b(rst_b), .rx_req(RX_DMA_REQ), .tx_req(TX_DMA_REQ),
    .rx_count(rx_cnt), .tx_count(tx_cnt));

  // ********
  // Bus and stimulus tasks
  // ********
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge CORE_CLK);
    aw_valid <= 1'b1;
    w_valid <= 1'b1;
    aw_addr <= a;
    w_data <= v;
    while (!(aw_done && w_done)) begin
      @(posedge CORE_CLK);
      if (!aw_done && AWREADY === 1'b1) begin
        aw_done = 1'b1;
        aw_valid <= 1'b0;
      end
      if (!w_done && WREADY === 1'b1) begin
        w_done = 1'b1;
        w_valid <= 1'b0;
      end
    end
    b_ready <= 1'b1;
    do @(posedge CORE_CLK); while (BVALID !== 1'b1);
    rs = BRESP;
    b_ready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge CORE_CLK);
    ar_valid <= 1'b1;
    ar_addr <= a;
    do @(posedge CORE_CLK); while (ARREADY !== 1'b1);
    ar_valid <= 1'b0;
    r_ready <= 1'b1;
    do @(posedge CORE_CLK); while (RVALID !== 1'b1);
    v = RDATA;
    rs = RRESP;
    r_ready <= 1'b0;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    rd(a, d, r);
    chk(d, exp);
  endtask

  task automatic fire(input logic [4:0] e, input logic [2:0] l);
    @(posedge CORE_CLK);
    evt <= e;
    lvl <= l;
    @(posedge CORE_CLK);
    evt <= 5'h00;
    @(posedge CORE_CLK);
  endtask

  task automatic report_and_stop;
    if (n_fail == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge CORE_CLK);
    n_fail++;
    report_and_stop();
  end

  // ********
  // Main sequence
  // ********
  initial begin
    repeat (4) @(posedge CORE_CLK);
    rst_b <= 1'b1;
    rchk(fifo_irq_pkg::OFS_TRIG, 32'h0000_0000);
    rchk(fifo_irq_pkg::OFS_ENSET, 32'h0000_0000);
    rchk(fifo_irq_pkg::OFS_STATUS, 32'h0000_0000);
    chk({31'h0, IRQ}, 32'h0000_0000);
    // Reserved bits are always written as zero
    for (int i = 0; i < 12; i++) begin
      wr(fifo_irq_pkg::OFS_TRIG, rows[i].cfg, r);
      rchk(fifo_irq_pkg::OFS_TRIG, rows[i].cfg);
      fire(rows[i].is_tx ? 5'h08 : 5'h10, rows[i].lvl);
      rchk(fifo_irq_pkg::OFS_STATUS, {28'h0, rows[i].st});
      wr(fifo_irq_pkg::OFS_STATUS, 32'h0000_000F, r);
    end
    chk({24'h0, rx_cnt}, 32'h0000_0004);
    chk({24'h0, tx_cnt}, 32'h0000_0004);
    // ********
    // Hand-written cases
    // ********
    rx_sel <= 1'b0;
    tx_sel <= 1'b0;
    wr(fifo_irq_pkg::OFS_TRIG, 32'h0000_0002, r);
    fire(5'h10, 3'h1);
    chk({31'h0, IRQ}, 32'h0000_0000);
    wr(fifo_irq_pkg::OFS_ENSET, 32'h0000_0005, r);
    wr(fifo_irq_pkg::OFS_ENSET, 32'h0000_0002, r);
    rchk(fifo_irq_pkg::OFS_ENSET, 32'h0000_0007);
    wr(fifo_irq_pkg::OFS_ENCLR, 32'h0000_0001, r);
    wr(fifo_irq_pkg::OFS_ENSET, 32'h0000_0000, r);
    rchk(fifo_irq_pkg::OFS_ENCLR, 32'h0000_0006);
    wr(fifo_irq_pkg::OFS_TRIG, 32'h0000_0003, r);
    fire(5'h08, 3'h0);
    chk({31'h0, IRQ}, 32'h0000_0001);
    // DMA selects are low, so request counts stay at 4
    @(posedge CORE_CLK);
    chk({24'h0, rx_cnt}, 32'h0000_0004);
    chk({24'h0, tx_cnt}, 32'h0000_0004);
    wr(fifo_irq_pkg::OFS_STATUS, 32'h0000_000F, r);
    chk({31'h0, IRQ}, 32'h0000_0000);
    fire(5'h02, 3'h0);
    chk({31'h0, IRQ}, 32'h0000_0000);
    fire(5'h04, 3'h0);
    chk({31'h0, IRQ}, 32'h0000_0001);
    rchk(fifo_irq_pkg::OFS_VIEW, 32'h0000_0002);
    rchk(fifo_irq_pkg::OFS_STATUS, 32'h0000_0003);
    wr(fifo_irq_pkg::OFS_STATUS, 32'h0000_0002, r);
    chk({31'h0, IRQ}, 32'h0000_0000);
    wr(fifo_irq_pkg::OFS_STATUS, 32'h0000_0001, r);
    fire(5'h01, 3'h0);
    rchk(fifo_irq_pkg::OFS_STATUS, 32'h0000_0001);
    wr(fifo_irq_pkg::OFS_ENSET, 32'h0000_0009, r);
    chk({31'h0, IRQ}, 32'h0000_0001);
    wr(fifo_irq_pkg::OFS_ENCLR, 32'h0000_000F, r);
    chk({31'h0, IRQ}, 32'h0000_0000);
    wr(fifo_irq_pkg::OFS_ENSET, 32'h0000_0008, r);
    // Clock enable low freezes the flags
    ce <= 1'b0;
    fire(5'h10, 3'h1);
    chk({31'h0, IRQ}, 32'h0000_0000);
    ce <= 1'b1;
    fire(5'h10, 3'h1);
    chk({31'h0, IRQ}, 32'h0000_0001);
    rchk(fifo_irq_pkg::OFS_VIEW, 32'h0000_0008);
    wr(12'hE00, 32'h0000_000F, r);
    chk({30'h0, r}, {30'h0, fifo_irq_pkg::RESP_SLV});
    rd(12'hE00, d, r);
    chk({30'h0, r}, {30'h0, fifo_irq_pkg::RESP_SLV});
    chk(d, fifo_irq_pkg::DATA_ZERO);
    // Reset in mid-run with state set
    rst_b <= 1'b0;
    repeat (4) @(posedge CORE_CLK);
    chk({31'h0, IRQ}, 32'h0000_0000);
    rst_b <= 1'b1;
    rchk(fifo_irq_pkg::OFS_TRIG, 32'h0000_0000);
    rchk(fifo_irq_pkg::OFS_ENSET, 32'h0000_0000);
    rchk(fifo_irq_pkg::OFS_STATUS, 32'h0000_0000);
    report_and_stop();
  end
endmodule // test_serial_fifo_level_trigger_irq
